// ---- hdl/uic_pkg.sv ----
// Notes on behaviour
// - Mode bit 0 enables MIDI support.
// - Mode bit 1 enables high speed.
// - Mode bits 3:2 pick enhanced baud.
// - First port bit 6 shares all ports.
// - First port bit 7 shares both UARTs.
// - Shared: either UART drives both lines.
// - Second port bit 5 floats transmit pin.
// - Float bit resets on standby reset only.
// - Infrared bit 0 selects receive polarity.
// - Infrared bit 1 transmit polarity, reset 0x02.
// - Infrared bit 2 selects half duplex.
// - Infrared bits 5:3 select port function.
// - Timeout register counts 100 us steps.
// - Receiver blanked during transmit plus timeout.
// - Timeout register resets to 0x03.
// - Ports live in devices 0x04 and 0x05.
// - Registers survive soft resets.
package uic_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] LDN_UART1     = 8'h04;
    localparam logic [7:0] LDN_UART2     = 8'h05;
    localparam logic [7:0] IDX_MODE      = 8'hf0;
    localparam logic [7:0] IDX_IR_OPT    = 8'hf1;
    localparam logic [7:0] IDX_HD_TMO    = 8'hf2;
    localparam logic [7:0] IDX_IRQ_STS   = 8'hf8;
    localparam logic [7:0] IDX_IRQ_MSK   = 8'hf9;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_MODE      = 8'h00;
    localparam logic [7:0] RST_IR_OPT    = 8'h02;
    localparam logic [7:0] RST_HD_TMO    = 8'h03;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int MODE_MIDI      = 0;
    localparam int MODE_HSPEED    = 1;
    localparam int MODE_BAUD_LO   = 2;
    localparam int MODE_BAUD_HI   = 3;
    localparam int MODE_TX_FLOAT  = 5;
    localparam int MODE_ALL_SHARE = 6;
    localparam int MODE_SHARE     = 7;
    localparam int IR_RX_POL      = 0;
    localparam int IR_TX_POL      = 1;
    localparam int IR_HALF_DUPLEX = 2;
    localparam int IR_FUNC_LO     = 3;
    localparam int IR_FUNC_HI     = 5;

    localparam int EV_UART1       = 0;
    localparam int EV_UART2       = 1;
    localparam int EV_BLANK_END   = 2;
    localparam int NUM_EV         = 3;

    typedef enum logic [1:0] {
        UIC_BAUD_STD  = 2'h0,
        UIC_BAUD_921K = 2'h1,
        UIC_BAUD_1M5  = 2'h2,
        UIC_BAUD_RSV  = 2'h3
    } uic_baud_e;

    typedef enum logic [2:0] {
        UIC_IR_STD   = 3'h0,
        UIC_IR_IRDA  = 3'h1,
        UIC_IR_ASK   = 3'h2
    } uic_ir_func_e;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int HD_STEP_US    = 100;
    localparam int HD_STEP_CYC   = (HD_STEP_US * 1000) / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Block state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]        u1_mode;
        logic [7:0]        u2_mode;
        logic [7:0]        ir_opt;
        logic [7:0]        hd_tmo;
        logic [NUM_EV-1:0] irq_sts;
        logic [NUM_EV-1:0] irq_msk;
        logic              irq_out;
        logic [7:0]        rdata;
        logic              u1_irq_d;
        logic              u2_irq_d;
        logic              u1_line;
        logic              u2_line;
        logic              tx_pin;
        logic              tx_oe;
        logic              rx_out;
        logic [7:0]        step;
        logic [15:0]       sub;
        logic              blank_d;
    } uic_state_s;

endpackage

// ---- hdl/uic_regs.sv ----
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ns
module uic_regs #(
    parameter int STEP_CYC = uic_pkg::HD_STEP_CYC
) (
    input  wire logic       i_mclk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_stby_rst,
    input  wire logic [7:0] i_ldn,
    input  wire logic [7:0] i_idx,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    input  wire logic       i_uart1_irq,
    input  wire logic       i_uart2_irq,
    output logic            o_uart1_irq_line,
    output logic            o_uart2_irq_line,
    output logic            o_all_share_irq,
    output logic            o_uart1_midi,
    output logic            o_uart1_high_speed,
    output logic      [1:0] o_uart1_baud_sel,
    output logic            o_uart2_midi,
    output logic            o_uart2_high_speed,
    output logic      [1:0] o_uart2_baud_sel,
    output logic      [2:0] o_ir_func,
    input  wire logic       i_tx2_data,
    input  wire logic       i_tx2_oe,
    input  wire logic       i_tx2_active,
    output logic            o_tx2_pin,
    output logic            o_tx2_pin_oe,
    input  wire logic       i_ir_rx,
    output logic            o_rx2_data,
    output logic            o_irq
);

    // ------------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------------
    if (STEP_CYC < 1 || STEP_CYC > 65536) begin : g_bad_step
        $error("STEP_CYC must lie between 1 and 65536");
    end

    localparam logic [15:0] STEP_LAST = 16'(STEP_CYC - 1);

    localparam uic_pkg::uic_state_s RESET_ST = '{
        u1_mode  : uic_pkg::RST_MODE,
        u2_mode  : uic_pkg::RST_MODE,
        ir_opt   : uic_pkg::RST_IR_OPT,
        hd_tmo   : uic_pkg::RST_HD_TMO,
        default  : '0
    };

    uic_pkg::uic_state_s st_r;
    uic_pkg::uic_state_s st_nxt;

    // ------------------------------------------------------------------
    // Decoded settings
    // ------------------------------------------------------------------
    logic                      share_any;
    logic                      ir_active;
    logic                      half_duplex;
    logic                      blank_now;
    logic                      rx_raw;
    logic [uic_pkg::NUM_EV-1:0] ev;
    logic [2:0]                ir_func;
    logic [1:0]                baud1;
    logic [1:0]                baud2;

    always_comb begin
        ir_func = st_r.ir_opt[uic_pkg::IR_FUNC_HI:uic_pkg::IR_FUNC_LO];
        // Reserved function codes fall back to plain serial behaviour.
        ir_active = (ir_func == uic_pkg::UIC_IR_IRDA) ||
                    (ir_func == uic_pkg::UIC_IR_ASK);
        half_duplex = ir_active && st_r.ir_opt[uic_pkg::IR_HALF_DUPLEX];
        share_any = st_r.u1_mode[uic_pkg::MODE_SHARE] ||
                    st_r.u1_mode[uic_pkg::MODE_ALL_SHARE];
        // Blanking covers the transmission and the trailing step count.
        blank_now = i_tx2_active || (st_r.step != 8'h00);
        rx_raw = ir_active ? (i_ir_rx ^ st_r.ir_opt[uic_pkg::IR_RX_POL]) : i_ir_rx;
        baud1 = st_r.u1_mode[uic_pkg::MODE_BAUD_HI:uic_pkg::MODE_BAUD_LO];
        baud2 = st_r.u2_mode[uic_pkg::MODE_BAUD_HI:uic_pkg::MODE_BAUD_LO];
        ev = '0;
        ev[uic_pkg::EV_UART1] = i_uart1_irq && !st_r.u1_irq_d;
        ev[uic_pkg::EV_UART2] = i_uart2_irq && !st_r.u2_irq_d;
        ev[uic_pkg::EV_BLANK_END] = half_duplex && st_r.blank_d && !blank_now;
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic keep_float;
        keep_float = st_r.u2_mode[uic_pkg::MODE_TX_FLOAT];
        st_nxt = st_r;
        st_nxt.rdata = 8'h00;

        // Register writes; reserved mode and infrared bits are stored but never acted on.
        if (i_wr) begin
            if (i_ldn == uic_pkg::LDN_UART1 && i_idx == uic_pkg::IDX_MODE) begin
                st_nxt.u1_mode = i_wdata;
            end else if (i_ldn == uic_pkg::LDN_UART2 && i_idx == uic_pkg::IDX_MODE) begin
                st_nxt.u2_mode = i_wdata;
            end else if (i_ldn == uic_pkg::LDN_UART2 && i_idx == uic_pkg::IDX_IR_OPT) begin
                st_nxt.ir_opt = i_wdata;
            end else if (i_ldn == uic_pkg::LDN_UART2 && i_idx == uic_pkg::IDX_HD_TMO) begin
                st_nxt.hd_tmo = i_wdata;
            end else if (i_ldn == uic_pkg::LDN_UART2 && i_idx == uic_pkg::IDX_IRQ_STS) begin
                st_nxt.irq_sts = st_r.irq_sts & ~i_wdata[uic_pkg::NUM_EV-1:0];
            end else if (i_ldn == uic_pkg::LDN_UART2 && i_idx == uic_pkg::IDX_IRQ_MSK) begin
                st_nxt.irq_msk = i_wdata[uic_pkg::NUM_EV-1:0];
            end
        end

        // New events win over a clear in the same cycle.
        st_nxt.irq_sts = st_nxt.irq_sts | ev;
        st_nxt.irq_out = |(st_nxt.irq_sts & st_nxt.irq_msk);

        // Register reads; unmapped locations return zero.
        if (i_rd) begin
            if (i_ldn == uic_pkg::LDN_UART1 && i_idx == uic_pkg::IDX_MODE) begin
                st_nxt.rdata = st_r.u1_mode;
            end else if (i_ldn == uic_pkg::LDN_UART2 && i_idx == uic_pkg::IDX_MODE) begin
                st_nxt.rdata = st_r.u2_mode;
            end else if (i_ldn == uic_pkg::LDN_UART2 && i_idx == uic_pkg::IDX_IR_OPT) begin
                st_nxt.rdata = st_r.ir_opt;
            end else if (i_ldn == uic_pkg::LDN_UART2 && i_idx == uic_pkg::IDX_HD_TMO) begin
                st_nxt.rdata = st_r.hd_tmo;
            end else if (i_ldn == uic_pkg::LDN_UART2 && i_idx == uic_pkg::IDX_IRQ_STS) begin
                st_nxt.rdata = {5'h00, st_r.irq_sts};
            end else if (i_ldn == uic_pkg::LDN_UART2 && i_idx == uic_pkg::IDX_IRQ_MSK) begin
                st_nxt.rdata = {5'h00, st_r.irq_msk};
            end
        end

        // Interrupt routing. With distinct lines assigned, sharing makes both fire.
        st_nxt.u1_irq_d = i_uart1_irq;
        st_nxt.u2_irq_d = i_uart2_irq;
        if (share_any) begin
            st_nxt.u1_line = i_uart1_irq || i_uart2_irq;
            st_nxt.u2_line = i_uart1_irq || i_uart2_irq;
        end else begin
            st_nxt.u1_line = i_uart1_irq;
            st_nxt.u2_line = i_uart2_irq;
        end

        // Transmit pin with polarity only in the infrared functions.
        st_nxt.tx_pin = ir_active ? (i_tx2_data ^ st_r.ir_opt[uic_pkg::IR_TX_POL])
                                  : i_tx2_data;
        st_nxt.tx_oe = i_tx2_oe && !st_r.u2_mode[uic_pkg::MODE_TX_FLOAT];

        // Half-duplex blanking timer: reloaded while transmitting, then counts
        // down one step every STEP_CYC cycles.
        if (i_tx2_active) begin
            st_nxt.step = st_r.hd_tmo;
            st_nxt.sub = 16'h0000;
        end else if (st_r.step != 8'h00) begin
            if (st_r.sub == STEP_LAST) begin
                st_nxt.sub = 16'h0000;
                st_nxt.step = st_r.step - 8'h01;
            end else begin
                st_nxt.sub = st_r.sub + 16'h0001;
            end
        end
        st_nxt.blank_d = blank_now;
        // A blanked receiver reads as idle, which is low after polarity.
        st_nxt.rx_out = (half_duplex && blank_now) ? 1'b0 : rx_raw;

        // Main reset keeps the standby-powered float bit; no soft reset input
        // exists, so nothing else clears these registers.
        if (i_stby_rst) begin
            st_nxt = RESET_ST;
        end else if (i_sys_rst) begin
            st_nxt = RESET_ST;
            st_nxt.u2_mode[uic_pkg::MODE_TX_FLOAT] = keep_float;
        end
    end

    always_ff @(posedge i_mclk) begin
        st_r <= st_nxt;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_rdata            = st_r.rdata;
    assign o_uart1_irq_line   = st_r.u1_line;
    assign o_uart2_irq_line   = st_r.u2_line;
    assign o_all_share_irq    = st_r.u1_mode[uic_pkg::MODE_ALL_SHARE];
    assign o_uart1_midi       = st_r.u1_mode[uic_pkg::MODE_MIDI];
    assign o_uart1_high_speed = st_r.u1_mode[uic_pkg::MODE_HSPEED];
    assign o_uart1_baud_sel   = baud1;
    assign o_uart2_midi       = st_r.u2_mode[uic_pkg::MODE_MIDI];
    assign o_uart2_high_speed = st_r.u2_mode[uic_pkg::MODE_HSPEED];
    assign o_uart2_baud_sel   = baud2;
    assign o_ir_func          = ir_func;
    assign o_tx2_pin          = st_r.tx_pin;
    assign o_tx2_pin_oe       = st_r.tx_oe;
    assign o_rx2_data         = st_r.rx_out;
    assign o_irq              = st_r.irq_out;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_rdata_only_after: assert property (@(posedge i_mclk) disable iff (i_sys_rst || i_stby_rst)
        !$past(i_rd) |-> o_rdata == 8'h00) else $error("read data outside its cycle");

    chk_midi_write: assert property (@(posedge i_mclk) disable iff (i_sys_rst || i_stby_rst)
        (i_wr && i_ldn == uic_pkg::LDN_UART1 && i_idx == uic_pkg::IDX_MODE)
        |=> o_uart1_midi == $past(i_wdata[uic_pkg::MODE_MIDI])
        && o_uart1_baud_sel == $past(i_wdata[uic_pkg::MODE_BAUD_HI:uic_pkg::MODE_BAUD_LO]))
        else $error("mode write not applied");

    chk_share_both: assert property (@(posedge i_mclk) disable iff (i_sys_rst || i_stby_rst)
        (share_any && i_uart1_irq) |=> o_uart1_irq_line && o_uart2_irq_line)
        else $error("shared interrupt missed a line");

    chk_no_share: assert property (@(posedge i_mclk) disable iff (i_sys_rst || i_stby_rst)
        (!share_any && i_uart1_irq && !i_uart2_irq) |=> o_uart1_irq_line && !o_uart2_irq_line)
        else $error("unshared interrupt leaked");

    chk_float_tx: assert property (@(posedge i_mclk) disable iff (i_sys_rst || i_stby_rst)
        st_r.u2_mode[uic_pkg::MODE_TX_FLOAT] |=> !o_tx2_pin_oe)
        else $error("transmit pin driven while forced off");

    chk_float_keep: assert property (@(posedge i_mclk) disable iff (i_stby_rst)
        (i_sys_rst && st_r.u2_mode[uic_pkg::MODE_TX_FLOAT])
        |=> st_r.u2_mode[uic_pkg::MODE_TX_FLOAT]) else $error("float bit lost on main reset");

    chk_reset_vals: assert property (@(posedge i_mclk) disable iff (i_stby_rst)
        $past(i_sys_rst) |-> st_r.hd_tmo == uic_pkg::RST_HD_TMO &&
        st_r.ir_opt == uic_pkg::RST_IR_OPT && st_r.u1_mode == uic_pkg::RST_MODE)
        else $error("reset values wrong");

    chk_blank_tx: assert property (@(posedge i_mclk) disable iff (i_sys_rst || i_stby_rst)
        (half_duplex && i_tx2_active) |=> !o_rx2_data) else $error("receiver not blanked");

    chk_blank_zero: assert property (@(posedge i_mclk) disable iff (i_sys_rst || i_stby_rst)
        (half_duplex && $fell(i_tx2_active) && st_r.hd_tmo == 8'h00 && $stable(st_r.ir_opt))
        |-> st_r.step == 8'h00) else $error("zero timeout still blanks");

    // A mask write in the same cycle may drop the event, so it is left out.
    chk_irq_level: assert property (@(posedge i_mclk) disable iff (i_sys_rst || i_stby_rst)
        ((ev & st_r.irq_msk) != '0 && !i_wr) |=> o_irq)
        else $error("interrupt output not raised");

    // ------------------------------------------------------------------
    // Checks on writes, pins, blanking timer, event status and standby reset
    // ------------------------------------------------------------------
    chk_hspeed_write: assert property (@(posedge i_mclk)
        disable iff (i_sys_rst || i_stby_rst)
        (i_wr && i_ldn == uic_pkg::LDN_UART1 && i_idx == uic_pkg::IDX_MODE)
        |=> o_uart1_high_speed == $past(i_wdata[uic_pkg::MODE_HSPEED]))
        else $error("high speed bit not applied");

    chk_u2_write: assert property (@(posedge i_mclk)
        disable iff (i_sys_rst || i_stby_rst)
        (i_wr && i_ldn == uic_pkg::LDN_UART2 && i_idx == uic_pkg::IDX_MODE)
        |=> o_uart2_midi == $past(i_wdata[uic_pkg::MODE_MIDI])
        && o_uart2_high_speed == $past(i_wdata[uic_pkg::MODE_HSPEED])
        && o_uart2_baud_sel == $past(i_wdata[uic_pkg::MODE_BAUD_HI:uic_pkg::MODE_BAUD_LO]))
        else $error("second port mode write not applied");

    chk_ir_func_write: assert property (@(posedge i_mclk)
        disable iff (i_sys_rst || i_stby_rst)
        (i_wr && i_ldn == uic_pkg::LDN_UART2 && i_idx == uic_pkg::IDX_IR_OPT)
        |=> o_ir_func == $past(i_wdata[uic_pkg::IR_FUNC_HI:uic_pkg::IR_FUNC_LO]))
        else $error("infrared function write not applied");

    chk_tmo_write: assert property (@(posedge i_mclk)
        disable iff (i_sys_rst || i_stby_rst)
        (i_wr && i_ldn == uic_pkg::LDN_UART2 && i_idx == uic_pkg::IDX_HD_TMO)
        |=> st_r.hd_tmo == $past(i_wdata))
        else $error("timeout write not applied");

    chk_unmapped_wr: assert property (@(posedge i_mclk)
        disable iff (i_sys_rst || i_stby_rst)
        (i_wr && (i_ldn == uic_pkg::LDN_UART1 ? i_idx != uic_pkg::IDX_MODE
                                               : i_ldn != uic_pkg::LDN_UART2))
        |=> $stable(st_r.u1_mode) && $stable(st_r.u2_mode) && $stable(st_r.ir_opt)
        && $stable(st_r.hd_tmo))
        else $error("unmapped write changed a register");

    chk_all_share: assert property (@(posedge i_mclk)
        disable iff (i_sys_rst || i_stby_rst)
        (st_r.u1_mode[uic_pkg::MODE_ALL_SHARE] && i_uart2_irq) |=> o_uart1_irq_line)
        else $error("all-port sharing missed a line");

    chk_float_off: assert property (@(posedge i_mclk)
        disable iff (i_sys_rst || i_stby_rst)
        !st_r.u2_mode[uic_pkg::MODE_TX_FLOAT] |=> o_tx2_pin_oe == $past(i_tx2_oe))
        else $error("transmit enable not followed");

    chk_tx_pol: assert property (@(posedge i_mclk)
        disable iff (i_sys_rst || i_stby_rst)
        (ir_active && st_r.ir_opt[uic_pkg::IR_TX_POL]) |=> o_tx2_pin == !$past(i_tx2_data))
        else $error("transmit polarity not applied");

    chk_plain_pins: assert property (@(posedge i_mclk)
        disable iff (i_sys_rst || i_stby_rst)
        !ir_active |=> o_tx2_pin == $past(i_tx2_data) && o_rx2_data == $past(i_ir_rx))
        else $error("plain serial pins altered");

    chk_rx_pol: assert property (@(posedge i_mclk)
        disable iff (i_sys_rst || i_stby_rst)
        (ir_active && !half_duplex && st_r.ir_opt[uic_pkg::IR_RX_POL])
        |=> o_rx2_data == !$past(i_ir_rx))
        else $error("receive polarity not applied");

    chk_full_duplex: assert property (@(posedge i_mclk)
        disable iff (i_sys_rst || i_stby_rst)
        (ir_active && !half_duplex && !st_r.ir_opt[uic_pkg::IR_RX_POL] && i_tx2_active)
        |=> o_rx2_data == $past(i_ir_rx))
        else $error("full duplex receiver blanked");

    chk_step_load: assert property (@(posedge i_mclk)
        disable iff (i_sys_rst || i_stby_rst)
        i_tx2_active |=> st_r.step == $past(st_r.hd_tmo))
        else $error("timeout not loaded during transmit");

    chk_blank_hold: assert property (@(posedge i_mclk)
        disable iff (i_sys_rst || i_stby_rst)
        (half_duplex && st_r.step != 8'h00) |=> !o_rx2_data)
        else $error("receiver not blanked after transmit");

    chk_sts_sticky: assert property (@(posedge i_mclk)
        disable iff (i_sys_rst || i_stby_rst)
        (st_r.irq_sts != '0 && !i_wr)
        |=> (st_r.irq_sts & $past(st_r.irq_sts)) == $past(st_r.irq_sts))
        else $error("status bit lost without a clear");

    chk_stby_defaults: assert property (@(posedge i_mclk)
        i_stby_rst |=> st_r == RESET_ST)
        else $error("standby reset left a register");

    cov_share: cover property (@(posedge i_mclk) share_any && i_uart2_irq ##1 o_uart1_irq_line);
    cov_blank_end: cover property (@(posedge i_mclk) ev[uic_pkg::EV_BLANK_END]);
    cov_float: cover property (@(posedge i_mclk) i_tx2_oe && !o_tx2_pin_oe);
    cov_float_keep: cover property (@(posedge i_mclk)
        i_sys_rst && st_r.u2_mode[uic_pkg::MODE_TX_FLOAT]);
    cov_zero_tmo: cover property (@(posedge i_mclk)
        half_duplex && $fell(i_tx2_active) && st_r.hd_tmo == 8'h00);

endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
    $display("wrong value at %0t ns: got %h expected %h", $time, (a), (b)); end end

module tb_top;
    // ------------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------------
    logic       i_mclk = 1'b0;
    logic       i_sys_rst, i_stby_rst, i_wr, i_rd;
    logic [7:0] i_ldn, i_idx, i_wdata, o_rdata;
    logic       i_uart1_irq, i_uart2_irq, o_uart1_irq_line, o_uart2_irq_line;
    logic       o_all_share_irq, o_uart1_midi, o_uart1_high_speed, o_uart2_midi;
    logic       o_uart2_high_speed, o_tx2_pin, o_tx2_pin_oe, o_rx2_data, o_irq;
    logic [1:0] o_uart1_baud_sel, o_uart2_baud_sel;
    logic [2:0] o_ir_func;
    logic       i_tx2_data, i_tx2_oe, i_tx2_active, i_ir_rx;
    int         err_total = 0;
    int         cmp_count = 0;

    always #2 i_mclk = ~i_mclk;

    // A short step keeps the half-duplex blanking tests to a few cycles.
    uic_regs #(.STEP_CYC(4)) uut (
        .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_stby_rst(i_stby_rst), .i_ldn(i_ldn),
        .i_idx(i_idx), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_uart1_irq(i_uart1_irq), .i_uart2_irq(i_uart2_irq),
        .o_uart1_irq_line(o_uart1_irq_line), .o_uart2_irq_line(o_uart2_irq_line),
        .o_all_share_irq(o_all_share_irq), .o_uart1_midi(o_uart1_midi),
        .o_uart1_high_speed(o_uart1_high_speed), .o_uart1_baud_sel(o_uart1_baud_sel),
        .o_uart2_midi(o_uart2_midi), .o_uart2_high_speed(o_uart2_high_speed),
        .o_uart2_baud_sel(o_uart2_baud_sel), .o_ir_func(o_ir_func),
        .i_tx2_data(i_tx2_data), .i_tx2_oe(i_tx2_oe), .i_tx2_active(i_tx2_active),
        .o_tx2_pin(o_tx2_pin), .o_tx2_pin_oe(o_tx2_pin_oe), .i_ir_rx(i_ir_rx),
        .o_rx2_data(o_rx2_data), .o_irq(o_irq)
    );

    // ------------------------------------------------------------------
    // Bus cycles and helpers
    // ------------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask

    task automatic wr(input logic [7:0] ldn, input logic [7:0] idx, input logic [7:0] d);
        @(posedge i_mclk);
        {i_ldn, i_idx, i_wdata, i_wr} <= {ldn, idx, d, 1'b1};
        @(posedge i_mclk);
        i_wr <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] ldn, input logic [7:0] idx, input logic [7:0] e);
        @(posedge i_mclk);
        {i_ldn, i_idx, i_rd} <= {ldn, idx, 1'b1};
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1;
        `CHK(o_rdata, e)
    endtask

    task automatic pulse_rst(input logic stby);
        @(posedge i_mclk);
        if (stby) i_stby_rst <= 1'b1; else i_sys_rst <= 1'b1;
        @(posedge i_mclk);
        {i_stby_rst, i_sys_rst} <= 2'b00;
        #1;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        rd_chk(8'h04, 8'hf0, 8'h00);
        rd_chk(8'h05, 8'hf0, 8'h00);
        rd_chk(8'h05, 8'hf1, 8'h02);
        rd_chk(8'h05, 8'hf2, 8'h03);
        `CHK({o_uart1_midi, o_uart1_high_speed, o_uart1_baud_sel}, 4'h0)
    endtask

    task automatic t_modes();
        for (int b = 0; b < 4; b++) begin
            wr(8'h04, 8'hf0, {4'h0, 2'(b), 2'b11});
            wr(8'h05, 8'hf0, {4'h0, 2'(3 - b), 2'b00});
            `CHK(o_uart1_baud_sel, 2'(b))
            `CHK(o_uart2_baud_sel, 2'(3 - b))
            `CHK({o_uart1_midi, o_uart1_high_speed}, 2'b11)
            `CHK({o_uart2_midi, o_uart2_high_speed}, 2'b00)
        end
        wr(8'h04, 8'hf0, 8'hff);
        rd_chk(8'h04, 8'hf0, 8'hff);
        `CHK(o_all_share_irq, 1'b1)
        wr(8'h04, 8'hf0, 8'h00);
        `CHK(o_all_share_irq, 1'b0)
    endtask

    task automatic t_share();
        logic [7:0] cfg [3] = '{8'h00, 8'h80, 8'h40};
        for (int s = 0; s < 3; s++) begin
            wr(8'h04, 8'hf0, cfg[s]);
            i_uart1_irq <= 1'b1;
            tick(2);
            `CHK({o_uart1_irq_line, o_uart2_irq_line}, {1'b1, s != 0})
            i_uart1_irq <= 1'b0;
            i_uart2_irq <= 1'b1;
            tick(2);
            `CHK({o_uart1_irq_line, o_uart2_irq_line}, {s != 0, 1'b1})
            i_uart2_irq <= 1'b0;
            tick(2);
        end
        wr(8'h04, 8'hf0, 8'h00);
    endtask

    task automatic t_irq();
        wr(8'h05, 8'hf8, 8'h07);
        wr(8'h05, 8'hf9, 8'h01);
        i_uart2_irq <= 1'b1;
        tick(3);
        `CHK(o_irq, 1'b0)
        rd_chk(8'h05, 8'hf8, 8'h02);
        i_uart1_irq <= 1'b1;
        tick(3);
        `CHK(o_irq, 1'b1)
        {i_uart1_irq, i_uart2_irq} <= 2'b00;
        wr(8'h05, 8'hf8, 8'h01);
        tick(2);
        `CHK(o_irq, 1'b0)
        rd_chk(8'h05, 8'hf8, 8'h02);
        rd_chk(8'h05, 8'hf9, 8'h01);
        wr(8'h04, 8'hf1, 8'hff);
        rd_chk(8'h04, 8'hf1, 8'h00);
        rd_chk(8'h06, 8'hf0, 8'h00);
    endtask

    task automatic t_float();
        i_tx2_oe <= 1'b1;
        wr(8'h05, 8'hf2, 8'h05);
        wr(8'h05, 8'hf0, 8'h20);
        tick(1);
        `CHK(o_tx2_pin_oe, 1'b0)
        pulse_rst(1'b0);
        rd_chk(8'h05, 8'hf0, 8'h20);
        rd_chk(8'h05, 8'hf2, 8'h03);
        pulse_rst(1'b1);
        rd_chk(8'h05, 8'hf0, 8'h00);
        tick(1);
        `CHK(o_tx2_pin_oe, 1'b1)
    endtask

    task automatic t_ir();
        logic [7:0] opt [4] = '{8'h02, 8'h0b, 8'h11, 8'h1b};
        logic       ir;
        for (int k = 0; k < 4; k++) begin
            ir = (opt[k][5:3] == 3'h1) || (opt[k][5:3] == 3'h2);
            wr(8'h05, 8'hf1, opt[k]);
            `CHK(o_ir_func, opt[k][5:3])
            for (int d = 0; d < 2; d++) begin
                {i_tx2_data, i_ir_rx} <= {2{1'(d)}};
                tick(2);
                `CHK(o_tx2_pin, 1'(d) ^ (ir & opt[k][1]))
                `CHK(o_rx2_data, 1'(d) ^ (ir & opt[k][0]))
            end
        end
    endtask

    // Blanking: a one-step timeout is four cycles here, plus one of output lag.
    task automatic t_blank();
        i_ir_rx <= 1'b1;
        wr(8'h05, 8'hf8, 8'h07);
        wr(8'h05, 8'hf1, 8'h08);
        i_tx2_active <= 1'b1;
        tick(3);
        `CHK(o_rx2_data, 1'b1)
        i_tx2_active <= 1'b0;
        wr(8'h05, 8'hf1, 8'h0c);
        wr(8'h05, 8'hf2, 8'h01);
        i_tx2_active <= 1'b1;
        tick(3);
        `CHK(o_rx2_data, 1'b0)
        i_tx2_active <= 1'b0;
        tick(4);
        `CHK(o_rx2_data, 1'b0)
        tick(1);
        `CHK(o_rx2_data, 1'b1)
        rd_chk(8'h05, 8'hf8, 8'h04);
        wr(8'h05, 8'hf2, 8'h00);
        i_tx2_active <= 1'b1;
        tick(3);
        `CHK(o_rx2_data, 1'b0)
        i_tx2_active <= 1'b0;
        tick(1);
        `CHK(o_rx2_data, 1'b1)
    endtask

    // ------------------------------------------------------------------
    // Verdict
    // ------------------------------------------------------------------
    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        {i_sys_rst, i_stby_rst} = 2'b11;
        {i_ldn, i_idx, i_wdata, i_wr, i_rd} = '0;
        {i_uart1_irq, i_uart2_irq, i_tx2_data, i_tx2_oe, i_tx2_active, i_ir_rx} = '0;
        repeat (10) @(posedge i_mclk);
        {i_sys_rst, i_stby_rst} <= 2'b00;
        t_reset();
        t_modes();
        t_share();
        t_irq();
        t_float();
        t_ir();
        t_blank();
        summarize();
    end

    // The scenarios need well under a thousand cycles; this allows ample slack.
    initial begin
        #40000;
        err_total++;
        summarize();
    end
endmodule
